//--- hw/t1_framer_consts.svh
// Constants for the T1 superframe and T1DM framer
`ifndef T1_FRAMER_CONSTS_SVH
`define T1_FRAMER_CONSTS_SVH

// ----------------------------------------------------------------
// Frame geometry
// ----------------------------------------------------------------
`define T1_FRAME_LAST   8'hc0
`define T1_MF_LAST      4'hb
`define T1_SIG_A_FRAME  4'h5
`define T1_SIG_B_FRAME  4'hb

// ----------------------------------------------------------------
// Framing bit pattern, frame 1 at the top bit
// ----------------------------------------------------------------
`define T1_FBIT_PATTERN 12'h8dc

// ----------------------------------------------------------------
// T1DM sync byte, first bit sent at the top bit
// ----------------------------------------------------------------
`define T1_SYNC_FIRST   8'hb9
`define T1_Y_POS        8'hbe
`define T1_R_POS        8'hbf
`define T1_SYNC_BYTE    8'hb8

// ----------------------------------------------------------------
// Receive alignment
// ----------------------------------------------------------------
`define T1_HUNT_LAST    5'h17
`define T1_HIST_FULL    5'h0b

`endif

//--- hw/t1_framer_pkg.sv
// Types for the T1 superframe and T1DM framer
package t1_framer_pkg;

  typedef enum logic [0:0] {
    HUNT   = 1'b0,
    LOCKED = 1'b1
  } align_e;

  typedef struct packed {
    logic [7:0]  txPos;
    logic [3:0]  txFrame;
    logic        txLine;
    logic        txTake;
    logic        txMfStart;
    logic        rxS1;
    logic        rxS2;
    logic        rxS3;
    logic        rxFilt;
    logic [7:0]  rxPos;
    logic [3:0]  rxFrame;
    align_e      rxState;
    logic [11:0] fHist;
    logic [4:0]  huntCnt;
    logic        rxBit;
    logic        rxBitValid;
    logic        rxIsSig;
    logic        rxIsCtrl;
    logic [4:0]  rxChannel;
    logic        rxMfStart;
    logic        remoteAlarm;
    logic        rxPerfBit;
    logic        rxPerfValid;
  } framer_s;

endpackage : t1_framer_pkg

//--- hw/t1_framer.sv
// T1 superframe and T1DM framer: line transmit and receive alignment
`include "t1_framer_consts.svh"

module t1_framer
  import t1_framer_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        lineBitEn,
  input  wire logic        t1dmMode,
  input  wire logic        txData,
  input  wire logic        txCtrl,
  input  wire logic [23:0] txSigA,
  input  wire logic [23:0] txSigB,
  input  wire logic        yellowAlarm,
  input  wire logic        txPerfBit,
  input  wire logic        rxLine,
  output logic             txLine,
  output logic             txTake,
  output logic             txMfStart,
  output logic             rxBit,
  output logic             rxBitValid,
  output logic             rxIsSig,
  output logic             rxIsCtrl,
  output logic [4:0]       rxChannel,
  output logic [3:0]       rxFrame,
  output logic             rxInSync,
  output logic             rxMfStart,
  output logic             remoteAlarm,
  output logic             rxPerfBit,
  output logic             rxPerfValid
);

  localparam logic [11:0] FPAT  = `T1_FBIT_PATTERN;
  localparam logic [7:0]  SYNCB = `T1_SYNC_BYTE;

  framer_s q;
  framer_s d;

  // ----------------------------------------------------------------
  // Position decode
  // ----------------------------------------------------------------
  logic [7:0] txPm1;
  logic [4:0] txCh;
  logic [2:0] txBi;
  logic [2:0] txSyncIdx;
  logic       txFExp;
  logic       sigSel;
  logic [7:0] rxPm1;
  logic [2:0] rxBi;
  logic       rxFExp;
  logic [11:0] histNext;

  assign txPm1     = q.txPos - 8'h01;
  assign txCh      = txPm1[7:3];
  assign txBi      = txPm1[2:0];
  assign txSyncIdx = 3'(q.txPos - `T1_SYNC_FIRST);
  assign txFExp    = FPAT[4'hb - q.txFrame];
  assign sigSel    = (q.txFrame == `T1_SIG_A_FRAME) ? txSigA[txCh] : txSigB[txCh];
  assign rxPm1     = q.rxPos - 8'h01;
  assign rxBi      = rxPm1[2:0];
  assign rxFExp    = FPAT[4'hb - q.rxFrame];
  assign histNext  = {q.fHist[10:0], q.rxFilt};

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    d             = q;
    d.txTake      = 1'b0;
    d.txMfStart   = 1'b0;
    d.rxBitValid  = 1'b0;
    d.rxPerfValid = 1'b0;
    d.rxMfStart   = 1'b0;

    // Pin synchroniser; a change counts once stages two and three agree
    d.rxS1 = rxLine;
    d.rxS2 = q.rxS1;
    d.rxS3 = q.rxS2;
    if (q.rxS2 == q.rxS3) begin
      d.rxFilt = q.rxS3;
    end

    if (lineBitEn) begin
      // Transmit side
      if (q.txPos == 8'h00) begin
        d.txLine    = txFExp;
        d.txMfStart = (q.txFrame == 4'h0);
      end else if (t1dmMode && q.txPos >= `T1_SYNC_FIRST) begin
        if (q.txPos == `T1_Y_POS) begin
          d.txLine = ~yellowAlarm;
        end else if (q.txPos == `T1_R_POS) begin
          d.txLine = txPerfBit;
        end else begin
          d.txLine = SYNCB[3'h7 - txSyncIdx];
        end
      end else if (txBi == 3'h7 && t1dmMode) begin
        d.txLine = txCtrl;
      end else if (txBi == 3'h7 && (q.txFrame == `T1_SIG_A_FRAME ||
                                    q.txFrame == `T1_SIG_B_FRAME)) begin
        d.txLine = sigSel;
      end else begin
        d.txLine = txData;
        d.txTake = 1'b1;
      end

      if (q.txPos == `T1_FRAME_LAST) begin
        d.txPos = 8'h00;
        d.txFrame = (q.txFrame == `T1_MF_LAST) ? 4'h0 : q.txFrame + 4'h1;
      end else begin
        d.txPos = q.txPos + 8'h01;
      end

      // Receive side
      d.rxPos = (q.rxPos == `T1_FRAME_LAST) ? 8'h00 : q.rxPos + 8'h01;
      if (q.rxPos == 8'h00) begin
        case (q.rxState)
          HUNT: begin
            d.fHist   = histNext;
            d.huntCnt = q.huntCnt + 5'h01;
            if (q.huntCnt >= `T1_HIST_FULL && histNext == FPAT) begin
              // Lock lands on the frame 12 framing bit; the rest of that frame is frame 12
              d.rxState = LOCKED;
              d.rxFrame = `T1_MF_LAST;
            end else if (q.huntCnt == `T1_HUNT_LAST) begin
              // Slip one bit: the next bit becomes the framing candidate
              d.rxPos   = 8'h00;
              d.fHist   = 12'h000;
              d.huntCnt = 5'h00;
            end
          end
          LOCKED: begin
            if (q.rxFilt != rxFExp) begin
              d.rxState = HUNT;
              d.fHist   = 12'h000;
              d.huntCnt = 5'h00;
            end else begin
              d.rxMfStart = (q.rxFrame == 4'h0);
            end
          end
          default: begin
            d.rxState = HUNT;
          end
        endcase
      end else if (q.rxState == LOCKED) begin
        if (t1dmMode && q.rxPos >= `T1_SYNC_FIRST) begin
          if (q.rxPos == `T1_Y_POS) begin
            d.remoteAlarm = ~q.rxFilt;
          end
          if (q.rxPos == `T1_R_POS) begin
            d.rxPerfBit   = q.rxFilt;
            d.rxPerfValid = 1'b1;
          end
        end else begin
          d.rxBit      = q.rxFilt;
          d.rxBitValid = 1'b1;
          d.rxChannel  = rxPm1[7:3];
          d.rxIsCtrl   = t1dmMode && rxBi == 3'h7;
          d.rxIsSig    = !t1dmMode && rxBi == 3'h7 &&
                         (q.rxFrame == `T1_SIG_A_FRAME ||
                          q.rxFrame == `T1_SIG_B_FRAME);
        end
      end
      if (q.rxState == LOCKED && q.rxPos == `T1_FRAME_LAST) begin
        d.rxFrame = (q.rxFrame == `T1_MF_LAST) ? 4'h0 : q.rxFrame + 4'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign txLine      = q.txLine;
  assign txTake      = q.txTake;
  assign txMfStart   = q.txMfStart;
  assign rxBit       = q.rxBit;
  assign rxBitValid  = q.rxBitValid;
  assign rxIsSig     = q.rxIsSig;
  assign rxIsCtrl    = q.rxIsCtrl;
  assign rxChannel   = q.rxChannel;
  assign rxFrame     = q.rxFrame;
  assign rxInSync    = q.rxState == LOCKED;
  assign rxMfStart   = q.rxMfStart;
  assign remoteAlarm = q.remoteAlarm;
  assign rxPerfBit   = q.rxPerfBit;
  assign rxPerfValid = q.rxPerfValid;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  frame_count_max_a: assert property (q.txFrame <= `T1_MF_LAST)
    else $error("frame counter beyond twelfth frame");

  frame_wrap_a: assert property (lineBitEn && q.txPos == `T1_FRAME_LAST &&
    q.txFrame == `T1_MF_LAST |=> q.txPos == 8'h00 && q.txFrame == 4'h0)
    else $error("multiframe did not wrap after bit 192 of frame 12");

  term_fbit_a: assert property (lineBitEn && q.txPos == 8'h00 && !q.txFrame[0]
    |=> q.txLine == !$past(q.txFrame[1]))
    else $error("terminal framing bit wrong");

  sig_fbit_a: assert property (lineBitEn && q.txPos == 8'h00 && q.txFrame[0]
    |=> q.txLine == ($past(q.txFrame) inside {4'h5, 4'h7, 4'h9}))
    else $error("signalling framing bit wrong");

  lock_pattern_a: assert property ($rose(q.rxState == LOCKED)
    |-> q.fHist == FPAT && $past(q.rxPos) == 8'h00)
    else $error("lock taken without full framing pattern");

  robbed_bit_a: assert property (lineBitEn && !t1dmMode && q.txPos != 8'h00 &&
    txBi == 3'h7 && (q.txFrame == 4'h5 || q.txFrame == 4'hb)
    |=> q.txLine == $past(sigSel) && !q.txTake)
    else $error("robbed signalling bit not sent");

  rx_channel_a: assert property (q.rxBitValid |-> q.rxChannel <= 5'h17)
    else $error("received channel out of range");

  sync_zero_a: assert property (lineBitEn && t1dmMode && q.txPos == 8'hba
    |=> !q.txLine)
    else $error("sync byte second bit not zero");

  ctrl_bit_a: assert property (lineBitEn && t1dmMode && q.txPos != 8'h00 &&
    q.txPos < `T1_SYNC_FIRST && txBi == 3'h7 |=> q.txLine == $past(txCtrl))
    else $error("control bit not sent in bit 8");

  yellow_bit_a: assert property (lineBitEn && t1dmMode && q.txPos == `T1_Y_POS
    |=> q.txLine == !$past(yellowAlarm))
    else $error("yellow alarm bit wrong polarity");

  perf_bit_a: assert property (lineBitEn && t1dmMode && q.txPos == `T1_R_POS
    |=> q.txLine == $past(txPerfBit))
    else $error("performance bit not passed through");

  first_bit_a: assert property (lineBitEn && q.txPos == 8'h01
    |=> q.txLine == $past(txData) && q.txTake)
    else $error("channel 1 bit 1 not sent after framing bit");

endmodule : t1_framer

//--- dv/t1_remote_term.sv
// Remote T1 terminal model that drives the receive line
module t1_remote_term (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       lineBitEn,
  input  wire logic       t1dmMode,
  input  wire logic       farYellow,
  input  wire logic       farPerf,
  input  wire logic       breakF,
  output logic            rxLine,
  output logic [7:0]      pos,
  output logic [3:0]      frame
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] FPAT = 12'h8dc;
  logic [7:0] nPos;
  logic [3:0] nFr;
  assign nPos = (pos == 8'hc0) ? 8'h00 : pos + 8'h01;
  assign nFr  = (pos != 8'hc0) ? frame : (frame == 4'hb) ? 4'h0 : frame + 4'h1;

  function automatic logic lineVal(input logic [7:0] p, input logic [3:0] f);
    logic [7:0] sync;
    sync = {5'h17, ~farYellow, farPerf, 1'b0};
    if (p == 8'h00) return FPAT[4'hb - f] ^ breakF;
    if (t1dmMode && p > 8'hb8) return sync[8'hc0 - p];
    return p[0] ^ p[4] ^ f[0] ^ f[2];
  endfunction : lineVal

  // Bit for the next position goes out right after the edge that took the last one
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pos    <= 8'h00;
      frame  <= 4'h0;
      rxLine <= 1'b1;
    end else if (lineBitEn) begin
      pos    <= nPos;
      frame  <= nFr;
      rxLine <= lineVal(nPos, nFr);
    end
  end
endmodule : t1_remote_term

//--- dv/tb_top.sv
// Self-checking bench for the T1 superframe and T1DM framer
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] FPAT = 12'h8dc;
  logic clk = 1'b0, rstn = 1'b0, lineBitEn = 1'b0, t1dmMode = 1'b0;
  logic txData = 1'b0, txCtrl = 1'b0, yellowAlarm = 1'b0, txPerfBit = 1'b0;
  logic farYellow = 1'b0, farPerf = 1'b0, breakF = 1'b0;
  logic [23:0] txSigA = 24'ha5c3f0, txSigB = 24'h3c5a0f;
  logic rxLine, txLine, txTake, txMfStart, rxBit, rxBitValid, rxIsSig, rxIsCtrl;
  logic rxInSync, rxMfStart, remoteAlarm, rxPerfBit, rxPerfValid;
  logic [4:0] rxChannel;
  logic [3:0] rxFrame, lFr, sFr, tFr = 4'h0;
  logic [7:0] lPos, sPos, tPos = 8'h00;
  logic [2:0] div = 3'h0;
  logic [1:0] eTx;
  logic txChk = 1'b0, rxChk = 1'b0, sLine, sMode, eMf;
  int numErrors = 0, nCompared = 0, cyc = 0;

  t1_framer dut (.clk(clk), .rstn(rstn), .lineBitEn(lineBitEn), .t1dmMode(t1dmMode),
    .txData(txData), .txCtrl(txCtrl), .txSigA(txSigA), .txSigB(txSigB),
    .yellowAlarm(yellowAlarm), .txPerfBit(txPerfBit), .rxLine(rxLine), .txLine(txLine),
    .txTake(txTake), .txMfStart(txMfStart), .rxBit(rxBit), .rxBitValid(rxBitValid),
    .rxIsSig(rxIsSig), .rxIsCtrl(rxIsCtrl), .rxChannel(rxChannel), .rxFrame(rxFrame),
    .rxInSync(rxInSync), .rxMfStart(rxMfStart), .remoteAlarm(remoteAlarm),
    .rxPerfBit(rxPerfBit), .rxPerfValid(rxPerfValid));
  t1_remote_term far (.clk(clk), .rstn(rstn), .lineBitEn(lineBitEn), .t1dmMode(t1dmMode),
    .farYellow(farYellow), .farPerf(farPerf), .breakF(breakF), .rxLine(rxLine),
    .pos(lPos), .frame(lFr));

  initial forever #2.5 clk = ~clk;

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    nCompared++;
    if (seen !== exp) begin
      numErrors++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic giveVerdict;
    $display("compared %0d, mismatches %0d", nCompared, numErrors);
    if (numErrors == 0 && nCompared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : giveVerdict

  function automatic logic [1:0] txExp(input logic [7:0] p, input logic [3:0] f);
    logic [2:0] b;
    logic [4:0] ch;
    logic [7:0] sb;
    b = 3'(p - 8'h01);
    ch = 5'((p - 8'h01) >> 3);
    sb = 8'hb8 | {5'h00, ~yellowAlarm, txPerfBit, 1'b0};
    if (p == 8'h00) return {FPAT[4'hb - f], 1'b0};
    if (t1dmMode && p > 8'hb8) return {sb[3'(8'hc0 - p)], 1'b0};
    if (t1dmMode && b == 3'h7) return {txCtrl, 1'b0};
    if (b == 3'h7 && f == 4'h5) return {txSigA[ch], 1'b0};
    if (b == 3'h7 && f == 4'hb) return {txSigB[ch], 1'b0};
    return {txData, 1'b1};
  endfunction : txExp

  // ----
  // Stimulus and stream monitors
  // ----
  always @(posedge clk) begin
    div <= (div == 3'h5) ? 3'h0 : div + 3'h1;
    // First line bit waits until the pin synchroniser holds the idle line level
    lineBitEn <= rstn && div == 3'h5 && cyc > 12;
    txData <= ~txData;
    txCtrl <= div[1];
    cyc++;
    if (cyc == 60000) begin
      numErrors++;
      giveVerdict();
    end
    if (txChk) begin
      check(txLine, eTx[1]);
      check(txTake, eTx[0]);
      check(txMfStart, eMf);
    end
    if (rxChk) begin
      check(rxMfStart, sPos == 8'h00 && sFr == 4'h0 && sLine == FPAT[4'hb]);
      check(rxBitValid, sPos != 8'h00 && !(sMode && sPos > 8'hb8));
      check(rxPerfValid, sMode && sPos == 8'hbf);
      if (rxPerfValid === 1'b1) check(rxPerfBit, sLine);
      if (sMode && sPos == 8'hbe) check(remoteAlarm, !sLine);
      if (rxBitValid === 1'b1) begin
        check(rxBit, sLine);
        check(rxChannel, 5'((sPos - 8'h01) >> 3));
        check(rxFrame, (sPos != 8'hc0) ? sFr : (sFr == 4'hb) ? 4'h0 : sFr + 4'h1);
        check(rxIsSig, !sMode && sPos[2:0] == 3'h0 && (sFr == 4'h5 || sFr == 4'hb));
        check(rxIsCtrl, sMode && sPos[2:0] == 3'h0);
      end
    end
    txChk <= rstn && lineBitEn;
    rxChk <= rstn && lineBitEn && rxInSync === 1'b1;
    if (rstn && lineBitEn) begin
      eTx <= txExp(tPos, tFr);
      eMf <= tPos == 8'h00 && tFr == 4'h0;
      tPos <= (tPos == 8'hc0) ? 8'h00 : tPos + 8'h01;
      tFr <= (tPos != 8'hc0) ? tFr : (tFr == 4'hb) ? 4'h0 : tFr + 4'h1;
      {sPos, sFr, sLine, sMode} <= {lPos, lFr, rxLine, t1dmMode};
    end
  end

  // ----
  // Scenarios
  // ----
  task automatic waitBits(input int n);
    repeat (n) @(posedge clk iff lineBitEn);
    repeat (2) @(posedge clk);
  endtask : waitBits

  task automatic sfLock;
    for (int k = 0; k < 20000 && rxInSync !== 1'b1; k++) @(posedge clk);
    check(rxInSync, 1'b1);
    waitBits(2316);
    check(rxInSync, 1'b1);
    $display("test sfLock done");
  endtask : sfLock

  task automatic t1dmRun;
    {t1dmMode, yellowAlarm, txPerfBit, farYellow, farPerf} <= 5'h1f;
    waitBits(2316);
    check(remoteAlarm, 1'b1);
    check(rxPerfBit, 1'b1);
    {yellowAlarm, txPerfBit, farYellow, farPerf} <= 4'h0;
    waitBits(386);
    check(remoteAlarm, 1'b0);
    check(rxPerfBit, 1'b0);
    t1dmMode <= 1'b0;
    $display("test t1dmRun done");
  endtask : t1dmRun

  task automatic fError;
    while (lPos !== 8'hc0) @(posedge clk);
    breakF <= 1'b1;
    @(posedge clk iff lineBitEn);
    breakF <= 1'b0;
    waitBits(1);
    check(rxInSync, 1'b0);
    repeat (48) begin
      @(posedge clk);
      check(rxBitValid, 1'b0);
    end
    $display("test fError done");
  endtask : fError

  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    sfLock();
    t1dmRun();
    fError();
    giveVerdict();
  end
endmodule : tb_top
